// *** inc/gd_pkg.sv ***
// constants, tables and types of the glyph display register file
// assumes one 20 MHz core clock that also serves as the display clock
// Behaviour
// - pointer selected, keeps data bits 3..0
// - row RAM selected, index picks row
// - row stores five bits, bit4 leftmost
// - flash select low: 8x1 flash memory
// - control word selected, all bits but pass bit 5
// - bits 2..0 dimming, 000 full, 111 blank
// - dimming shortens column duty, same peak
// - bit 3 enables per-digit flashing
// - flash and blink divide clock by 28672
// - bit 4 blinks all, overrides flashing
// - bit 6 starts test, bit 5 pass
// - ROM checksum compared, sets pass bit
// - checkerboard then inverse shown on LEDs
// - self test lasts 262144 clocks, no writes
// - test end: blanks, word zero but pass bit, pointer ones
// - character write: code or glyph index
// - reads return stored registers and memories
// - clear leaves glyph rows, settings intact
// - clear fills blanks within three cycles
// - reset clears flash, word, counters, blanks
// - write captured on rising write strobe

package gd_pkg;

  // ==========================================================
  // timing
  // ==========================================================
  localparam int CORE_CLK_HZ = 20000000; // display clock rate
  localparam int FLASH_DIV_DEF = 28672; // clocks per flash period
  localparam int SELFTEST_CLKS_DEF = 262144; // self test length
  localparam int CLEAR_CLKS = 3; // clear completes within this
  localparam int ROM_ENTRIES = 128; // character ROM depth
  localparam int PWM_STEPS = 15; // dimming frame length

  // ==========================================================
  // storage shapes
  // ==========================================================
  localparam int DIGITS = 8;
  localparam int GLYPH_SLOTS = 16;
  localparam int GLYPH_ROWS = 7;
  localparam int GLYPH_COLS = 5;

  // ==========================================================
  // control word fields
  // ==========================================================
  localparam int CW_CLEAR = 7;
  localparam int CW_TEST_RUN = 6;
  localparam int CW_TEST_PASS = 5;
  localparam int CW_BLINK = 4;
  localparam int CW_FLASH = 3;
  localparam int CW_DIM_HI = 2;

  // ==========================================================
  // character cell encoding and reset values
  // ==========================================================
  localparam int CHAR_GLYPH_BIT = 7; // one marks a glyph index
  localparam logic [7:0] CHAR_BLANK = 8'h20;
  localparam logic [7:0] CW_RESET = 8'h00;
  localparam logic [3:0] PTR_AFTER_TEST = 4'hf;
  localparam logic [2:0] ROW_INVALID = 3'h7;

  // on-time per dimming code out of PWM_STEPS (100..0 percent)
  localparam logic [3:0] DIM_DUTY [8] = '{
    4'hf, 4'hc, 4'h8, 4'h6, 4'h4, 4'h3, 4'h2, 4'h0
  };

  // self test sequence
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_ROM,
    SEQ_CHECK,
    SEQ_INVERSE
  } gd_test_e;

endpackage

// *** inc/gd_rate_if.sv ***
// rate bundle between the register file and its rate generator
// assumes both ends sit on the core clock
`timescale 1ns/1ps

interface gd_rate_if;
  logic [2:0] dimming_code; // current dimming selection
  logic flash_phase; // half-period on/off of the flash rate, one period per FLASH_DIV clocks
  logic column_on; // column drive duty gate

  modport gen (
    input dimming_code,
    output flash_phase,
    output column_on
  );
  modport user (
    output dimming_code,
    input flash_phase,
    input column_on
  );
endinterface

// *** rtl/gd_rate_gen.sv ***
// flash/blink rate divider and dimming duty generator
// assumes reset restarts both counters so cascaded parts stay aligned
`timescale 1ns/1ps

module gd_rate_gen
  import gd_pkg::*;
#(
  parameter int FLASH_DIV = FLASH_DIV_DEF
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  gd_rate_if.gen rate
);

  localparam int DW = $clog2(FLASH_DIV);

  logic [DW-1:0] div_q; // flash period counter
  logic [3:0] pwm_q; // dimming frame counter

  // ==========================================================
  // flash and blink rate
  // ==========================================================
  // one full on/off period every FLASH_DIV clocks
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= '0;
      rate.flash_phase <= 1'b1;
    end else begin
      if (div_q == DW'(FLASH_DIV - 1)) begin
        div_q <= '0;
      end else begin
        div_q <= div_q + 1'b1;
      end
      rate.flash_phase <= (div_q < DW'(FLASH_DIV / 2));
    end
  end

  // ==========================================================
  // dimming
  // ==========================================================
  // shorter on-time per frame, peak drive untouched
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwm_q <= '0;
      rate.column_on <= 1'b0;
    end else begin
      if (pwm_q == 4'(PWM_STEPS - 1)) begin
        pwm_q <= '0;
      end else begin
        pwm_q <= pwm_q + 1'b1;
      end
      // code 000 always on, 111 never on
      rate.column_on <= (pwm_q < DIM_DUTY[rate.dimming_code]);
    end
  end

endmodule

// *** rtl/gd_regfile.sv ***
// glyph display register file: bus decode, memories, control word,
// clear and self test sequencing
// assumes bus pins are asynchronous to core_clk_i; the character ROM
// answers combinationally on rom_data_i for rom_addr_o
`timescale 1ns/1ps

module gd_regfile
  import gd_pkg::*;
#(
  parameter int FLASH_DIV = FLASH_DIV_DEF,
  parameter int SELFTEST_CLKS = SELFTEST_CLKS_DEF,
  parameter int ROM_W = 35,
  parameter logic [ROM_W-1:0] ROM_SUM = '0 // arbitrary expected sum
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic chip_select_n_i,
  input wire logic write_n_i,
  input wire logic read_n_i,
  input wire logic flash_access_select_n_i,
  input wire logic region_select_high_i,
  input wire logic region_select_low_i,
  input wire logic [2:0] cell_index_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_n_o,
  output logic [DIGITS-1:0] digit_lit_o,
  output logic column_on_o,
  output logic selftest_active_o,
  output logic checker_inverse_o,
  output logic [6:0] rom_addr_o,
  input wire logic [ROM_W-1:0] rom_data_i
);

  localparam int CW = $clog2(SELFTEST_CLKS + 1);
  localparam int HALF = (SELFTEST_CLKS - ROM_ENTRIES) / 2;
  localparam logic [CW-1:0] ROM_END = CW'(ROM_ENTRIES - 1);
  localparam logic [CW-1:0] CHK_END = CW'(ROM_ENTRIES + HALF - 1);
  localparam logic [CW-1:0] TEST_END = CW'(SELFTEST_CLKS - 1);

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  localparam int PW = 17; // bundled asynchronous pin count

  logic [PW-1:0] pin_meta_q; // first stage, read only by second
  logic [PW-1:0] pin_q; // settled pins
  logic wr_n_prev_q; // previous settled write strobe

  // two flops on every pin before any decode
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta_q <= {3'h7, 14'h0};
      pin_q <= {3'h7, 14'h0};
    end else begin
      pin_meta_q <= {chip_select_n_i, write_n_i, read_n_i,
                     flash_access_select_n_i, region_select_high_i,
                     region_select_low_i, cell_index_i, data_i};
      pin_q <= pin_meta_q;
    end
  end

  logic cs_n, wr_n, rd_n, oth_sel, rsh, rsl;
  logic [2:0] idx;
  logic [7:0] wdat;
  assign {cs_n, wr_n, rd_n, oth_sel, rsh, rsl, idx, wdat} = pin_q;

  // write strobe history for the rising edge
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_n_prev_q <= 1'b1;
    end else begin
      wr_n_prev_q <= wr_n;
    end
  end

  // ==========================================================
  // decode
  // ==========================================================
  logic busy; // clear or self test in progress
  logic wr_stb; // one-cycle write pulse
  logic sel_flash, sel_ptr, sel_row, sel_char, sel_ctrl;

  // data taken on the low-to-high write strobe edge
  assign wr_stb = wr_n & ~wr_n_prev_q & ~cs_n & ~busy;
  assign sel_flash = ~oth_sel; // region lines ignored
  assign sel_ptr = oth_sel & ~rsh & ~rsl;
  assign sel_row = oth_sel & ~rsh & rsl;
  assign sel_ctrl = oth_sel & rsh & ~rsl;
  assign sel_char = oth_sel & rsh & rsl;

  // ==========================================================
  // storage
  // ==========================================================
  logic [3:0] ptr_q; // glyph slot pointer
  logic [7:0] ctrl_q; // display attribute word
  logic [DIGITS-1:0] flash_q; // per-digit flash bits
  logic [7:0] char_q [DIGITS]; // character cells
  logic [GLYPH_COLS-1:0] glyph_q [GLYPH_SLOTS][GLYPH_ROWS];
  logic [1:0] clr_cnt_q; // clear progress
  logic clr_fill; // clear fill cycle
  logic test_start, test_done;
  gd_test_e state_q;
  logic [CW-1:0] tcnt_q;
  logic [ROM_W-1:0] sum_q;

  // fill happens on the first busy cycle, bit 7 drops later
  assign clr_fill = ctrl_q[CW_CLEAR] && (clr_cnt_q == 2'h0);
  assign test_start = wr_stb & sel_ctrl & wdat[CW_TEST_RUN];
  assign test_done = (state_q == SEQ_INVERSE) && (tcnt_q == TEST_END);
  // device stops taking writes, reads still served, while it clears or
  assign busy = ctrl_q[CW_CLEAR] | (state_q != SEQ_IDLE);

  // glyph pointer keeps the low nibble only
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ptr_q <= '0;
    end else if (test_done) begin
      ptr_q <= PTR_AFTER_TEST;
    end else if (wr_stb && sel_ptr) begin
      ptr_q <= wdat[3:0];
    end
  end

  // glyph rows: no reset, contents untouched by clear
  always_ff @(posedge core_clk_i) begin
    // row seven is not a row, so the write is dropped
    if (wr_stb && sel_row && idx != ROW_INVALID) begin
      // bit 4 is the leftmost column, one lights the dot
      glyph_q[ptr_q][idx] <= wdat[GLYPH_COLS-1:0];
    end
  end

  // flash bits: host writes, clear, reset and test end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flash_q <= '0;
    end else if (clr_fill || test_done) begin
      flash_q <= '0;
    end else if (wr_stb && sel_flash) begin
      flash_q[idx] <= wdat[0];
    end
  end

  // character cells, one per digit
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < DIGITS; i++) begin
        char_q[i] <= CHAR_BLANK;
      end
    end else if (clr_fill || test_done) begin
      for (int i = 0; i < DIGITS; i++) begin
        char_q[i] <= CHAR_BLANK;
      end
    end else if (wr_stb && sel_char) begin
      if (wdat[CHAR_GLYPH_BIT]) begin
        // glyph slot form keeps only the index
        char_q[idx] <= {1'b1, 3'h0, wdat[3:0]};
      end else begin
        char_q[idx] <= {1'b0, wdat[6:0]};
      end
    end
  end

  // ==========================================================
  // control word
  // ==========================================================
  // clear cycle count, up from zero; the host waits these cycles out
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clr_cnt_q <= '0;
    end else if (!ctrl_q[CW_CLEAR]) begin
      clr_cnt_q <= '0;
    end else begin
      clr_cnt_q <= clr_cnt_q + 1'b1;
    end
  end

  // attribute word; pass bit is hardware owned
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= CW_RESET;
    end else if (test_done) begin
      // all zero but the verdict
      ctrl_q <= CW_RESET;
      ctrl_q[CW_TEST_PASS] <= (sum_q == ROM_SUM);
    end else if (wr_stb && sel_ctrl) begin
      ctrl_q <= {wdat[7:6], ctrl_q[CW_TEST_PASS], wdat[4:0]};
      if (wdat[CW_TEST_RUN]) begin
        ctrl_q[CW_TEST_PASS] <= 1'b0; // verdict pending
      end
    end else if (ctrl_q[CW_CLEAR] &&
                 clr_cnt_q == 2'(CLEAR_CLKS - 1)) begin
      // only bit 7 self-clears, other settings stay
      ctrl_q[CW_CLEAR] <= 1'b0;
    end
  end

  // ==========================================================
  // self test
  // ==========================================================
  // the host has pulsed reset beforehand, so storage is clean
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= SEQ_IDLE;
      tcnt_q <= '0;
    end else begin
      // one counter spans all phases, so the total length is exact
      case (state_q)
        SEQ_IDLE: begin
          tcnt_q <= '0;
          if (test_start) begin
            state_q <= SEQ_ROM;
          end
        end
        SEQ_ROM: begin
          tcnt_q <= tcnt_q + 1'b1;
          if (tcnt_q == ROM_END) begin
            state_q <= SEQ_CHECK;
          end
        end
        SEQ_CHECK: begin
          tcnt_q <= tcnt_q + 1'b1;
          if (tcnt_q == CHK_END) begin
            state_q <= SEQ_INVERSE;
          end
        end
        SEQ_INVERSE: begin
          tcnt_q <= tcnt_q + 1'b1;
          if (test_done) begin
            state_q <= SEQ_IDLE; // whole run is fixed length
          end
        end
        default: begin
          state_q <= SEQ_IDLE;
        end
      endcase
    end
  end

  // step the ROM through every entry and sum its output
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sum_q <= '0;
      rom_addr_o <= '0;
    end else if (state_q == SEQ_ROM) begin
      sum_q <= sum_q + rom_data_i;
      rom_addr_o <= rom_addr_o + 1'b1;
    end else begin
      if (test_start) begin
        sum_q <= '0;
      end
      rom_addr_o <= '0;
    end
  end

  // ==========================================================
  // rates and display gating
  // ==========================================================
  gd_rate_if rate ();

  assign rate.dimming_code = ctrl_q[CW_DIM_HI:0];

  gd_rate_gen #(
    .FLASH_DIV(FLASH_DIV)
  ) u_rate (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .rate(rate)
  );

  // per-digit lit gate; blink wins over flash
  // each digit owns a flop, so no two processes write one variable
  for (genvar g = 0; g < DIGITS; g++) begin : g_digit
    logic lit_q; // this digit lit in the current phase
    always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
        lit_q <= 1'b1;
      end else if (state_q != SEQ_IDLE) begin
        lit_q <= 1'b1; // test lights every LED
      end else if (ctrl_q[CW_BLINK]) begin
        lit_q <= rate.flash_phase;
      end else if (ctrl_q[CW_FLASH] && flash_q[g]) begin
        lit_q <= rate.flash_phase;
      end else begin
        lit_q <= 1'b1; // steady lit: flashing off or this digit's flash bit clear
      end
    end
    assign digit_lit_o[g] = lit_q;
  end

  // test patterns run at full drive, otherwise dimmed duty
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      column_on_o <= 1'b0;
      selftest_active_o <= 1'b0;
      checker_inverse_o <= 1'b0;
    end else begin
      column_on_o <= (state_q != SEQ_IDLE) | rate.column_on;
      selftest_active_o <= (state_q != SEQ_IDLE);
      checker_inverse_o <= (state_q == SEQ_INVERSE);
    end
  end

  // ==========================================================
  // read back
  // ==========================================================
  logic [7:0] rd_mux;

  // stored form returned, unused upper bits zero
  always_comb begin
    rd_mux = 8'h00;
    if (sel_flash) begin
      rd_mux = {7'h0, flash_q[idx]};
    end else if (sel_ptr) begin
      rd_mux = {4'h0, ptr_q};
    end else if (sel_row) begin
      if (idx != ROW_INVALID) begin
        rd_mux = {3'h0, glyph_q[ptr_q][idx]};
      end else begin
        rd_mux = 8'h00;
      end
    end else if (sel_ctrl) begin
      rd_mux = ctrl_q;
    end else if (sel_char) begin
      rd_mux = char_q[idx];
    end
  end

  // drive the bus while chip select and read are low, write high
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_o <= 8'h00;
      data_oe_n_o <= 1'b1;
    end else begin
      data_o <= rd_mux;
      data_oe_n_o <= ~(~cs_n & ~rd_n & wr_n);
    end
  end

endmodule

// *** test/gd_regfile_chk.sv ***
// port checker for the glyph display register file
// assumes it is bound into gd_regfile with the same test length
`timescale 1ns/1ps

module gd_regfile_chk #(
  parameter int SELFTEST_CLKS = 400
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic chip_select_n_i,
  input wire logic write_n_i,
  input wire logic read_n_i,
  input wire logic flash_access_select_n_i,
  input wire logic region_select_high_i,
  input wire logic region_select_low_i,
  input wire logic [2:0] cell_index_i,
  input wire logic [7:0] data_o,
  input wire logic data_oe_n_o,
  input wire logic [7:0] digit_lit_o,
  input wire logic selftest_active_o,
  input wire logic checker_inverse_o,
  input wire logic [6:0] rom_addr_o
);
  // =========
  // helper logic
  // =========
  localparam int INV_AT = 128 + (SELFTEST_CLKS - 128) / 2;
  logic rd_ok; // read cycle at the pins
  logic oth_sel; // a region other than the flash bits selected
  logic [19:0] act_q; // cycles of self test so far
  assign rd_ok = !chip_select_n_i && !read_n_i && write_n_i;
  assign oth_sel = flash_access_select_n_i;

  // restarts each test, so a long count from an old test cannot leak
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_q <= '0;
    end else begin
      act_q <= selftest_active_o ? act_q + 20'h1 : '0;
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // =========
  // assertions
  // =========
  chk_reset_idle_outs: assert property (
    $fell(rst_i) |-> data_oe_n_o && digit_lit_o == 8'hff
    && !selftest_active_o && rom_addr_o == 7'h0)
    else $error("outputs not idle after reset");
  chk_read_drives_bus: assert property (
    rd_ok [*4] |=> !data_oe_n_o) else $error("read left bus undriven");
  chk_bus_gets_released: assert property (
    read_n_i [*4] |=> data_oe_n_o) else $error("bus not released");
  chk_ptr_upper_zero: assert property (
    (rd_ok && oth_sel && !region_select_high_i && !region_select_low_i) [*4]
    |=> data_o[7:4] == 4'h0) else $error("pointer read upper bits set");
  chk_flash_upper_zero: assert property (
    (rd_ok && !oth_sel) [*4] |=> data_o[7:1] == 7'h0)
    else $error("flash read upper bits set");
  chk_row7_reads_zero: assert property (
    (rd_ok && oth_sel && !region_select_high_i && region_select_low_i
    && cell_index_i == 3'h7) [*4] |=> data_o == 8'h00)
    else $error("row seven read not zero");
  chk_test_length: assert property (
    $fell(selftest_active_o) |-> act_q >= SELFTEST_CLKS - 1
    && act_q <= SELFTEST_CLKS + 1) else $error("self test length wrong");
  chk_inverse_half: assert property (
    $rose(checker_inverse_o) |-> act_q >= INV_AT - 2 && act_q <= INV_AT + 2)
    else $error("inverse pattern started at wrong time");
  chk_inverse_in_test: assert property (
    checker_inverse_o |-> selftest_active_o)
    else $error("inverse pattern outside self test");
  chk_rom_steps_up: assert property (
    selftest_active_o && $past(selftest_active_o) && $changed(rom_addr_o)
    |-> rom_addr_o == $past(rom_addr_o) + 7'h1)
    else $error("rom address skipped");
endmodule

// *** test/gd_host_model.sv ***
// host processor model driving the parallel display bus
// assumes one core clock; pins change only just after a rising edge
`timescale 1ns/1ps

module gd_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic cs_n_o,
  output logic wr_n_o,
  output logic rd_n_o,
  output logic flash_n_o,
  output logic hi_o,
  output logic lo_o,
  output logic [2:0] idx_o,
  output logic [7:0] data_o
);
  // =========
  // idle bus
  // =========
  initial begin
    {cs_n_o, wr_n_o, rd_n_o, flash_n_o, hi_o, lo_o} = 6'h3f;
    idx_o = 3'h0;
    data_o = 8'h00;
  end

  // =========
  // bus cycles, region is {flash_n, hi, lo}
  // =========
  // strobe low and high three clocks each, data held round the rise
  task automatic host_write(input logic [2:0] r, input logic [2:0] i,
                            input logic [7:0] d);
    @(posedge clk_i);
    {flash_n_o, hi_o, lo_o} <= r;
    idx_o <= i;
    data_o <= d;
    cs_n_o <= 1'b0;
    wr_n_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    wr_n_o <= 1'b1; // data taken on this rising edge
    repeat (3) @(posedge clk_i);
    cs_n_o <= 1'b1;
    data_o <= ~d; // released bus must not keep the old value
    repeat (2) @(posedge clk_i);
  endtask

  // read data is settled three clocks after the pins, taken at five
  task automatic host_read(input logic [2:0] r, input logic [2:0] i,
                           output logic [7:0] d);
    @(posedge clk_i);
    {flash_n_o, hi_o, lo_o} <= r;
    idx_o <= i;
    cs_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    repeat (5) @(posedge clk_i);
    d = rdata_i;
    rd_n_o <= 1'b1;
    cs_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// *** test/testbench.sv ***
// self-checking testbench for the glyph display register file
// assumes the host model owns every bus pin; the rom is a ramp
`timescale 1ns/1ps

module testbench;
  import gd_pkg::*;
  localparam logic [2:0] R_PTR = 3'b100; // region {flash_n, hi, lo}
  localparam logic [2:0] R_ROW = 3'b101;
  localparam logic [2:0] R_CTRL = 3'b110;
  localparam logic [2:0] R_CHAR = 3'b111;
  localparam logic [2:0] R_FLASH = 3'b000;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic chip_select_n_i, write_n_i, read_n_i, flash_access_select_n_i;
  logic region_select_high_i, region_select_low_i, data_oe_n_o;
  logic column_on_o, selftest_active_o, checker_inverse_o;
  logic [2:0] cell_index_i;
  logic [7:0] data_i, data_o, digit_lit_o;
  logic [6:0] rom_addr_o;
  logic [34:0] rom_data_i;
  int n_fail = 0;
  int check_count = 0;
  assign rom_data_i = {28'h0, rom_addr_o}; // sum of 0..127 is 1fc0

  initial forever #25 core_clk_i = ~core_clk_i;

  gd_regfile #(.FLASH_DIV(16), .SELFTEST_CLKS(400),
    .ROM_SUM(35'h1fc0)) uut (.core_clk_i, .rst_i, .chip_select_n_i,
    .write_n_i, .read_n_i, .flash_access_select_n_i, .region_select_high_i,
    .region_select_low_i, .cell_index_i, .data_i, .data_o, .data_oe_n_o,
    .digit_lit_o, .column_on_o, .selftest_active_o, .checker_inverse_o,
    .rom_addr_o, .rom_data_i);
  gd_host_model u_host (.clk_i(core_clk_i), .rdata_i(data_o),
    .cs_n_o(chip_select_n_i), .wr_n_o(write_n_i), .rd_n_o(read_n_i),
    .flash_n_o(flash_access_select_n_i), .hi_o(region_select_high_i),
    .lo_o(region_select_low_i), .idx_o(cell_index_i), .data_o(data_i));

  // =========
  // shared tasks
  // =========
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic expect_rd(input logic [2:0] r, input logic [2:0] i,
                           input logic [7:0] want);
    logic [7:0] d;
    u_host.host_read(r, i, d);
    check(d, want);
  endtask
  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge core_clk_i); // no access for four clocks
  endtask
  // over two flash periods: digits seen dark, column and digit 1 counts
  task automatic watch(output logic [7:0] dk, output logic [7:0] nc,
                       output logic [7:0] n1);
    dk = 8'h00;
    nc = 8'h00;
    n1 = 8'h00;
    repeat (32) begin
      @(negedge core_clk_i);
      dk = dk | ~digit_lit_o;
      nc = nc + {7'h0, column_on_o};
      n1 = n1 + {7'h0, ~digit_lit_o[1]};
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // =========
  // scenarios
  // =========
  task automatic t_reset_state;
    for (int i = 0; i < 8; i++) begin
      expect_rd(R_CHAR, 3'(i), CHAR_BLANK);
      expect_rd(R_FLASH, 3'(i), 8'h00);
    end
    expect_rd(R_CTRL, 3'h0, CW_RESET);
    $display("test reset_state done");
  endtask

  // slot 5 rows carry junk in bits 7..5, slot 3 rows are zero
  task automatic t_glyph;
    u_host.host_write(R_PTR, 3'h0, 8'ha5);
    expect_rd(R_PTR, 3'h6, 8'h05);
    for (int i = 0; i < 8; i++) u_host.host_write(R_ROW, 3'(i), 8'he3 ^ 8'(i));
    u_host.host_write(R_PTR, 3'h0, 8'h03);
    for (int i = 0; i < 7; i++) u_host.host_write(R_ROW, 3'(i), 8'h00);
    u_host.host_write(R_PTR, 3'h0, 8'h05);
    for (int i = 0; i < 8; i++) begin
      expect_rd(R_ROW, 3'(i), i == 7 ? 8'h00 : 8'(3 ^ i));
    end
    $display("test glyph done");
  endtask

  // region lines vary on flash writes, odd digits get flash set
  task automatic t_flash_char;
    for (int i = 0; i < 8; i++) begin
      u_host.host_write({1'b0, 2'(i)}, 3'(i), {7'h7f, i[0]});
      u_host.host_write(R_CHAR, 3'(i), i == 2 ? 8'h8c : 8'h41 + 8'(i));
    end
    for (int i = 0; i < 8; i++) begin
      expect_rd(R_FLASH, 3'(i), {7'h0, i[0]});
      expect_rd(R_CHAR, 3'(i), i == 2 ? 8'h8c : 8'h41 + 8'(i));
    end
    $display("test flash_char done");
  endtask

  task automatic t_control;
    logic [7:0] dk, nc, n1;
    u_host.host_write(R_CTRL, 3'h0, 8'h3f);
    expect_rd(R_CTRL, 3'h0, 8'h1f);
    u_host.host_write(R_CTRL, 3'h0, 8'h07);
    watch(dk, nc, n1);
    check(nc, 8'h00);
    u_host.host_write(R_CTRL, 3'h0, 8'h00);
    watch(dk, nc, n1);
    check(nc, 8'h20);
    check(dk, 8'h00);
    u_host.host_write(R_CTRL, 3'h0, 8'h08);
    watch(dk, nc, n1);
    check(dk, 8'haa);
    check(n1, 8'h10);
    u_host.host_write(R_CTRL, 3'h0, 8'h18);
    watch(dk, nc, n1);
    check(dk, 8'hff);
    check(n1, 8'h10);
    $display("test control done");
  endtask

  task automatic t_clear;
    u_host.host_write(R_CTRL, 3'h0, 8'h8b);
    expect_rd(R_CTRL, 3'h0, 8'h0b);
    expect_rd(R_CHAR, 3'h2, CHAR_BLANK);
    expect_rd(R_FLASH, 3'h3, 8'h00);
    expect_rd(R_ROW, 3'h1, 8'h02);
    $display("test clear done");
  endtask

  task automatic t_selftest;
    int n;
    logic saw_inv;
    n = 0;
    saw_inv = 1'b0;
    do_reset();
    u_host.host_write(R_CTRL, 3'h0, 8'h40);
    // bus stays quiet for the whole
    while (selftest_active_o === 1'b1 && n < 1000) begin
      @(posedge core_clk_i);
      n++;
      saw_inv = saw_inv | checker_inverse_o;
    end
    check({7'h0, saw_inv}, 8'h01);
    check({7'h0, selftest_active_o}, 8'h00);
    expect_rd(R_CTRL, 3'h0, 8'h20);
    expect_rd(R_PTR, 3'h0, {4'h0, PTR_AFTER_TEST});
    expect_rd(R_CHAR, 3'h0, CHAR_BLANK);
    $display("test selftest done");
  endtask

  // =========
  // main sequence and watchdog
  // =========
  initial begin
    do_reset();
    t_reset_state();
    t_glyph();
    t_flash_char();
    t_control();
    t_clear();
    t_selftest();
    give_verdict();
  end
  // whole run needs about 1400 clocks
  initial begin
    repeat (8000) @(posedge core_clk_i);
    n_fail++;
    give_verdict();
  end
endmodule

bind gd_regfile gd_regfile_chk #(.SELFTEST_CLKS(SELFTEST_CLKS)) u_chk (
  .core_clk_i, .rst_i, .chip_select_n_i, .write_n_i, .read_n_i,
  .flash_access_select_n_i, .region_select_high_i, .region_select_low_i,
  .cell_index_i, .data_o, .data_oe_n_o, .digit_lit_o, .selftest_active_o,
  .checker_inverse_o, .rom_addr_o);
